// *** design/epi_detect.sv ***
// Operation
// - Polarity bit 0 low active, 1 high
// - Sixteen-bit read/write polarity register
// - Sixteen-bit enable register gates each pin
// - Reset clears polarity, enable, request registers
// - Bit 7 flags any pin 0-7
// - Bit 6 flags any pin 8-15
// - Bits 5-0 flag IRQ line requests
// - Edge requests stay until software clears
// - Write 0 clears read flag; 1 keeps
// - Two-bit sense: fall, rise, low, reserved
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "epi_defines.svh"
module epi_detect #(
	parameter int PORT_PINS = 16, // Port interrupt pin count.
	parameter int IRQ_LINES = 6 // IRQ line count.
) (
	input wire logic core_clk, // Block clock, 250 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [PORT_PINS-1:0] port_interrupt_pin, // Port pins.
	input wire logic [IRQ_LINES-1:0] irq_pin, // IRQ lines.
	input wire epi_pkg::epi_addr_t reg_addr, // Register address.
	input wire epi_pkg::epi_word_t reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output epi_pkg::epi_word_t reg_rdata, // Read data, cycle after.
	output logic irq_out // Level interrupt to the core.
);
	import epi_pkg::*;

	// Pin synchronisers; the first stage feeds only the second.
	logic [PORT_PINS-1:0] port_meta;
	logic [PORT_PINS-1:0] port_sync;
	logic [IRQ_LINES-1:0] irq_meta;
	logic [IRQ_LINES-1:0] irq_sync;
	logic [IRQ_LINES-1:0] irq_prev; // Last sampled IRQ level.

	// Software visible registers.
	logic [15:0] port_irq_polarity; // Active level per port pin.
	logic [15:0] port_irq_enable; // Gate per port pin.
	logic [IRQ_LINES-1:0] irq_flag; // Latched IRQ request flags.
	logic [2*IRQ_LINES-1:0] irq_sense; // Two sense bits per line.
	logic [7:0] ev_status; // Sticky event bits.
	logic [7:0] ev_mask; // Interrupt mask, 1 passes.
	logic [IRQ_LINES-1:0] read_seen; // Flags that software saw at 1.

	// Derived request state.
	logic [PORT_PINS-1:0] port_req; // Enabled pins at active level.
	logic low_port_group_flag; // Any of pins 0-7.
	logic high_port_group_flag; // Any of pins 8-15.
	logic [7:0] external_request_flags; // Request register image.
	logic [7:0] prev_request; // Request image one cycle ago.
	logic [IRQ_LINES-1:0] wr_clear; // Software clear this cycle.
	logic wr_req; // Write to the request register.
	logic rd_req; // Read of the request register.
	logic rd_status; // Read of the status register.

	assign wr_req = reg_wr && (reg_addr == `EPI_OFF_REQUEST);
	assign rd_req = reg_rd && (reg_addr == `EPI_OFF_REQUEST);
	assign rd_status = reg_rd && (reg_addr == `EPI_OFF_STATUS);

	// Two-flop synchronisers for all asynchronous pins.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_meta <= '0;
			port_sync <= '0;
			irq_meta <= '1;
			irq_sync <= '1;
			irq_prev <= '1;
		end else begin
			port_meta <= port_interrupt_pin;
			port_sync <= port_meta;
			irq_meta <= irq_pin;
			irq_sync <= irq_meta;
			irq_prev <= irq_sync;
		end
	end

	// Port pin qualification: XNOR with polarity, then enable gate.
	genvar gp;
	generate
		for (gp = 0; gp < PORT_PINS; gp++) begin : g_port
			// A pin asks while its level equals its polarity bit.
			assign port_req[gp] = port_irq_enable[gp] &&
				(port_sync[gp] == port_irq_polarity[gp]);
		end
	endgenerate

	// Each group flag is a live OR; it has no storage of its own.
	assign low_port_group_flag = |port_req[7:0];
	assign high_port_group_flag = |port_req[15:8];

	// Request register image as software reads it.
	always_comb begin
		external_request_flags = `EPI_RST_8;
		external_request_flags[`EPI_BIT_LOW_GRP] = low_port_group_flag;
		external_request_flags[`EPI_BIT_HIGH_GRP] = high_port_group_flag;
		external_request_flags[`EPI_IRQ_MSB:0] = irq_flag;
	end

	// Per-line clear: a written 0 counts only on a flag seen as 1.
	always_comb begin
		wr_clear = '0;
		if (wr_req) begin
			wr_clear = ~reg_wdata[`EPI_IRQ_MSB:0] & read_seen;
		end
	end

	// Polarity and enable registers, cleared at reset only.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_irq_polarity <= `EPI_RST_16;
			port_irq_enable <= `EPI_RST_16;
		end else if (reg_wr) begin
			if (reg_addr == `EPI_OFF_POLARITY) begin
				port_irq_polarity <= reg_wdata;
			end
			if (reg_addr == `EPI_OFF_ENABLE) begin
				port_irq_enable <= reg_wdata;
			end
		end
	end

	// Sense fields and event mask.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_sense <= `EPI_RST_SENSE;
			ev_mask <= `EPI_RST_8;
		end else if (reg_wr) begin
			if (reg_addr == `EPI_OFF_SENSE) begin
				irq_sense <= reg_wdata[2*IRQ_LINES-1:0];
			end
			if (reg_addr == `EPI_OFF_MASK) begin
				ev_mask <= reg_wdata[7:0];
			end
		end
	end

	// Remember which flags a read returned as 1; a later 0 clears them.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_seen <= '0;
		end else if (rd_req) begin
			read_seen <= irq_flag;
		end else begin
			read_seen <= read_seen & irq_flag;
		end
	end

	// IRQ flag update, one line per generate entry.
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_LINES; gi++) begin : g_irq
			logic [1:0] sense; // This line's sense field.
			logic edge_hit; // Selected edge seen this cycle.
			assign sense = irq_sense[2*gi+1:2*gi];
			always_comb begin
				case (sense)
					`EPI_SENSE_FALL: edge_hit = irq_prev[gi] && !irq_sync[gi];
					`EPI_SENSE_RISE: edge_hit = !irq_prev[gi] && irq_sync[gi];
					default: edge_hit = 1'b0;
				endcase
			end
			// Edge modes hold until cleared; a new edge beats the clear.
			always_ff @(posedge core_clk) begin
				if (rst) begin
					irq_flag[gi] <= 1'b0;
				end else if (sense == `EPI_SENSE_LOW) begin
					irq_flag[gi] <= !irq_sync[gi];
				end else if (sense == `EPI_SENSE_RSVD) begin
					// Reserved sense never raises a request.
					irq_flag[gi] <= 1'b0;
				end else if (edge_hit) begin
					irq_flag[gi] <= 1'b1;
				end else if (wr_clear[gi]) begin
					irq_flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Rising bits of the request image set sticky status bits.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_request <= `EPI_RST_8;
			ev_status <= `EPI_RST_8;
		end else begin
			prev_request <= external_request_flags;
			// A new event wins over the read that clears the register.
			ev_status <= (rd_status ? `EPI_RST_8 : ev_status) |
				(external_request_flags & ~prev_request);
		end
	end

	// Interrupt output is a level while any unmasked status bit stands.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(ev_status & ev_mask);
		end
	end

	// Read data are registered; unmapped addresses read zero.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= `EPI_RST_16;
		end else if (reg_rd) begin
			case (reg_addr)
				`EPI_OFF_POLARITY: reg_rdata <= port_irq_polarity;
				`EPI_OFF_ENABLE: reg_rdata <= port_irq_enable;
				`EPI_OFF_REQUEST: reg_rdata <= {8'h00, external_request_flags};
				`EPI_OFF_SENSE: reg_rdata <= {4'h0, irq_sense};
				`EPI_OFF_STATUS: reg_rdata <= {8'h00, ev_status};
				`EPI_OFF_MASK: reg_rdata <= {8'h00, ev_mask};
				default: reg_rdata <= `EPI_RST_16;
			endcase
		end else begin
			reg_rdata <= `EPI_RST_16;
		end
	end

	// Group flags trail the pins by the two sync flops, checked end to end.
	a_group_low: assert property (
		@(posedge core_clk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |->
		low_port_group_flag == |(port_irq_enable[7:0] &
		~($past(port_interrupt_pin[7:0], 2) ^
		port_irq_polarity[7:0])))
		else $error("low group flag wrong");

	// The high group obeys the same end-to-end relation.
	a_group_high: assert property (
		@(posedge core_clk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |->
		high_port_group_flag == |(port_irq_enable[15:8] &
		~($past(port_interrupt_pin[15:8], 2) ^
		port_irq_polarity[15:8])))
		else $error("high group flag wrong");

	// Disabled pins never raise the low group flag.
	a_enable_gate: assert property (
		@(posedge core_clk) disable iff (rst)
		(port_irq_enable[7:0] == 8'h00) |-> !low_port_group_flag)
		else $error("disabled pins raised flag");

	// A polarity write is held from the next edge on.
	a_polarity_store: assert property (
		@(posedge core_clk) disable iff (rst)
		(reg_wr && reg_addr == `EPI_OFF_POLARITY) |=>
		port_irq_polarity == $past(reg_wdata))
		else $error("polarity not stored");

	// Line 2 in low-level mode follows the inverse of its synced pin one edge later.
	a_level_track: assert property (
		@(posedge core_clk) disable iff (rst)
		(irq_sense[5:4] == `EPI_SENSE_LOW) |=>
		irq_flag[2] == !$past(irq_sync[2]))
		else $error("level flag not tracking");

	// Line 0 in an edge mode with its flag set.
	sequence s_edge_set;
		irq_flag[0] && irq_sense[1] == 1'b0;
	endsequence

	// An edge flag holds while no qualified clear is written.
	a_edge_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		s_edge_set ##0 !wr_clear[0] ##1 irq_sense[1] == 1'b0 |->
		irq_flag[0])
		else $error("edge flag dropped");

	// Writing 1 leaves a set edge flag alone.
	a_write_one: assert property (
		@(posedge core_clk) disable iff (rst)
		(wr_req && reg_wdata[0] && irq_flag[0] && irq_sense[1] == 1'b0)
		|=> (irq_sense[1] != 1'b0) || irq_flag[0])
		else $error("write 1 changed flag");

	// A qualified clear with no new edge drops the flag.
	a_clear_zero: assert property (
		@(posedge core_clk) disable iff (rst)
		(wr_clear[0] && !g_irq[0].edge_hit && irq_sense[1] == 1'b0) |=>
		!irq_flag[0])
		else $error("clear ignored");

	// One edge after reset polarity, enable, the IRQ flags and both outputs are back at zero.
	a_reset_zero: assert property (
		@(posedge core_clk)
		rst |=> (port_irq_polarity == `EPI_RST_16) &&
		(port_irq_enable == `EPI_RST_16) && (irq_flag == '0) &&
		(reg_rdata == `EPI_RST_16) && !irq_out)
		else $error("reset value wrong");

	// Request image bits 5-0 are the IRQ flags.
	a_irq_field: assert property (
		@(posedge core_clk) disable iff (rst)
		external_request_flags[`EPI_IRQ_MSB:0] == irq_flag)
		else $error("irq field wrong");

	// Bit 7 is the low group.
	a_low_bit: assert property (
		@(posedge core_clk) disable iff (rst)
		external_request_flags[`EPI_BIT_LOW_GRP] == |port_req[7:0])
		else $error("bit 7 wrong");

	// Bit 6 is the high group.
	a_high_bit: assert property (
		@(posedge core_clk) disable iff (rst)
		external_request_flags[`EPI_BIT_HIGH_GRP] == |port_req[15:8])
		else $error("bit 6 wrong");

	// Polarity 1 with enable, pin high: the low group asks.
	a_pol_high: assert property (
		@(posedge core_clk) disable iff (rst)
		(port_irq_enable[0] && port_irq_polarity[0] && port_sync[0]) |->
		low_port_group_flag)
		else $error("polarity sense wrong");

	// Polarity 0 with enable, pin low: the high group asks.
	a_pol_low: assert property (
		@(posedge core_clk) disable iff (rst)
		(port_irq_enable[15] && !port_irq_polarity[15] && !port_sync[15])
		|-> high_port_group_flag)
		else $error("low polarity sense wrong");

	// Edges on the synced lines in the direction that each line selects.
	sequence s_fall_seen;
		irq_sense[1:0] == `EPI_SENSE_FALL && irq_prev[0] && !irq_sync[0];
	endsequence
	sequence s_rise_seen;
		irq_sense[3:2] == `EPI_SENSE_RISE && !irq_prev[1] && irq_sync[1];
	endsequence

	// A falling edge sets the line 0 flag on the next edge.
	a_sense_fall: assert property (
		@(posedge core_clk) disable iff (rst)
		s_fall_seen |=> irq_flag[0])
		else $error("falling edge missed");

	// A rising edge sets the line 1 flag on the next edge.
	a_sense_rise: assert property (
		@(posedge core_clk) disable iff (rst)
		s_rise_seen |=> irq_flag[1])
		else $error("rising edge missed");

	// A reserved sense field keeps the line 3 flag at zero.
	a_reserved_zero: assert property (
		@(posedge core_clk) disable iff (rst)
		(irq_sense[7:6] == `EPI_SENSE_RSVD) |=> !irq_flag[3])
		else $error("reserved sense raised flag");

	// An unmasked status bit raises the interrupt one edge later.
	a_irq_level: assert property (
		@(posedge core_clk) disable iff (rst)
		(|(ev_status & ev_mask)) |=> irq_out)
		else $error("interrupt output low");

endmodule : epi_detect

// *** design/epi_defines.svh ***
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
// Register offsets on the plain register port.
`define EPI_ADDR_W 4
`define EPI_OFF_POLARITY 4'h0
`define EPI_OFF_ENABLE 4'h1
`define EPI_OFF_REQUEST 4'h2
`define EPI_OFF_SENSE 4'h3
`define EPI_OFF_STATUS 4'h4
`define EPI_OFF_MASK 4'h5
// Reset values.
`define EPI_RST_16 16'h0000
`define EPI_RST_8 8'h00
`define EPI_RST_SENSE 12'h000
// Request register field positions.
`define EPI_BIT_LOW_GRP 7
`define EPI_BIT_HIGH_GRP 6
`define EPI_IRQ_MSB 5
// Sense field encodings.
`define EPI_SENSE_FALL 2'h0
`define EPI_SENSE_RISE 2'h1
`define EPI_SENSE_LOW 2'h2
`define EPI_SENSE_RSVD 2'h3
`endif

// *** design/epi_pkg.sv ***
package epi_pkg;
	// Register data word as seen on the register port.
	typedef logic [15:0] epi_word_t;
	// Register port address.
	typedef logic [3:0] epi_addr_t;
endpackage : epi_pkg

// *** verif/epi_src.sv ***
`timescale 1ns/10ps
// Behavioural stand-in for the external request sources on the pins.
module epi_src (
	input wire logic core_clk, // Block clock.
	input wire logic [15:0] port_req, // Wanted port pin levels.
	input wire logic [5:0] irq_req, // Wanted IRQ line levels.
	output logic [15:0] port_interrupt_pin, // Driven port pins.
	output logic [5:0] irq_pin // Driven IRQ lines.
);
	// Lines idle high, so a falling edge needs a real drop to happen.
	initial begin
		port_interrupt_pin = 16'h0000;
		irq_pin = 6'h3F;
	end
	// Sources change just after the clock edge, like real board logic.
	always @(posedge core_clk) begin
		port_interrupt_pin <= port_req;
		irq_pin <= irq_req;
	end
endmodule : epi_src

// *** verif/tb.sv ***
`timescale 1ns/10ps
`include "epi_defines.svh"
module tb;
	import epi_pkg::*;
	logic core_clk = 1'b0; // Block clock.
	logic rst = 1'b1; // Synchronous reset.
	logic [15:0] port_req = 16'h0000; // Port pin levels to drive.
	logic [5:0] irq_req = 6'h3F; // IRQ line levels to drive.
	logic [15:0] port_interrupt_pin; // Port pins.
	logic [5:0] irq_pin; // IRQ lines.
	epi_addr_t reg_addr = 4'h0; // Register address.
	epi_word_t reg_wdata = 16'h0000; // Write data.
	logic reg_wr = 1'b0; // Write strobe.
	logic reg_rd = 1'b0; // Read strobe.
	epi_word_t reg_rdata; // Read data.
	logic irq_out; // Interrupt level.
	int errors = 0; // Mismatch count.
	int comparisons = 0; // Comparison count.
	int cycles = 0; // Cycles run, for the hang guard.
	epi_word_t junk; // Discarded read data.
	// The clock toggles every half period of 2 ns.
	always #2 core_clk = ~core_clk;
	epi_src src (.core_clk(core_clk), .port_req(port_req),
		.irq_req(irq_req), .port_interrupt_pin(port_interrupt_pin),
		.irq_pin(irq_pin));
	epi_detect dut (.core_clk(core_clk), .rst(rst),
		.port_interrupt_pin(port_interrupt_pin), .irq_pin(irq_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// A hung handshake would otherwise run forever.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end
	// Compares one value with its expectation.
	task automatic chk(input epi_word_t seen, input epi_word_t exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle write strobe.
	task automatic wr(input epi_addr_t a, input epi_word_t d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// One-cycle read strobe; data stand only in the following cycle.
	task automatic rd(input epi_addr_t a, output epi_word_t v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// Reads and compares in one call.
	task automatic rc(input epi_addr_t a, input epi_word_t e);
		epi_word_t v;
		rd(a, v);
		chk(v, e);
	endtask : rc
	// Pins pass a model flop and two sync flops, so wait them out.
	task automatic settle();
		repeat (6) @(posedge core_clk);
	endtask : settle
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rc(`EPI_OFF_REQUEST, 16'h0000);
		rc(4'h6, 16'h0000);
		wr(`EPI_OFF_POLARITY, 16'hA5C3);
		rc(`EPI_OFF_POLARITY, 16'hA5C3);
		wr(`EPI_OFF_ENABLE, 16'h3C5A);
		rc(`EPI_OFF_ENABLE, 16'h3C5A);
		// Port groups with high-active pins, then low-active pins 8 and 15.
		wr(`EPI_OFF_POLARITY, 16'hFFFF);
		wr(`EPI_OFF_ENABLE, 16'h0001);
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0000);
		port_req <= 16'h0101;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0080);
		wr(`EPI_OFF_ENABLE, 16'h0101);
		rc(`EPI_OFF_REQUEST, 16'h00C0);
		wr(`EPI_OFF_POLARITY, 16'hFEFF);
		rc(`EPI_OFF_REQUEST, 16'h0080);
		port_req <= 16'h0000;
		wr(`EPI_OFF_POLARITY, 16'h0000);
		wr(`EPI_OFF_ENABLE, 16'h8000);
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0040);
		// Unused pins are disabled, as software is expected to do.
		wr(`EPI_OFF_ENABLE, 16'h0000);
		// Line 0 falling, 1 rising, 2 low level, 3 reserved.
		wr(`EPI_OFF_SENSE, 16'h00E4);
		wr(`EPI_OFF_MASK, 16'h0001);
		rc(`EPI_OFF_SENSE, 16'h00E4);
		rc(`EPI_OFF_MASK, 16'h0001);
		rd(`EPI_OFF_STATUS, junk);
		irq_req <= 6'h3E;
		settle();
		#1 chk({15'h0000, irq_out}, 16'h0001);
		rc(`EPI_OFF_REQUEST, 16'h0001);
		irq_req <= 6'h3F;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0001);
		wr(`EPI_OFF_REQUEST, 16'h00FF);
		rc(`EPI_OFF_REQUEST, 16'h0001);
		wr(`EPI_OFF_REQUEST, 16'h00FE);
		rc(`EPI_OFF_REQUEST, 16'h0000);
		rc(`EPI_OFF_STATUS, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk({15'h0000, irq_out}, 16'h0000);
		// A drop on the rising-edge line must not count.
		irq_req <= 6'h3D;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0000);
		irq_req <= 6'h3F;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0002);
		chk({15'h0000, irq_out}, 16'h0000);
		irq_req <= 6'h3B;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0006);
		irq_req <= 6'h37;
		settle();
		rc(`EPI_OFF_REQUEST, 16'h0002);
		rc(`EPI_OFF_REQUEST, 16'h0002);
		wr(`EPI_OFF_REQUEST, 16'h00FD);
		rc(`EPI_OFF_REQUEST, 16'h0000);
		// A second reset in mid-run clears polarity, enable and request again.
		irq_req <= 6'h3F;
		wr(`EPI_OFF_POLARITY, 16'h1234);
		wr(`EPI_OFF_ENABLE, 16'h4321);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rc(`EPI_OFF_POLARITY, 16'h0000);
		rc(`EPI_OFF_ENABLE, 16'h0000);
		rc(`EPI_OFF_REQUEST, 16'h0000);
		tally_and_finish();
	end
endmodule : tb
